// >>> rtl/lec_event_counters.sv
`timescale 1ns/1ns
module lec_event_counters
   import lec_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic         rst_b,
   input  wire logic [31:0]  mr_addr,
   input  wire logic         mr_rd,
   input  wire logic         mr_wr,
   input  wire logic [63:0]  mr_wdata,
   output logic      [63:0]  mr_rdata,
   output logic              mr_ack,
   output logic              mr_err,
   input  wire logic         pc_rd,
   input  wire logic [31:0]  pc_index,
   output logic      [31:0]  pc_rdata_lo,
   output logic      [31:0]  pc_rdata_hi,
   output logic              pc_ack,
   output logic              pc_err,
   input  wire logic [1:0]   inbound_bus_queue_event,
   input  wire logic [1:0]   snoop_queue_event,
   input  wire logic [1:0]   external_bus_event,
   input  wire logic [15:0]  lat_weight,
   output logic      [191:0] ev_qual,
   output logic      [5:0]   ev_armed,
   output logic              lat_active
);

   typedef struct packed {
      logic [63:0] lat_ctl;
      logic [63:0] lat_cnt;
      logic [63:0] mr_rdata;
      logic        mr_ack;
      logic        mr_err;
      logic [31:0] pc_lo;
      logic        pc_ack;
      logic        pc_err;
   } lec_top_state_type;

   lec_top_state_type st_reg;
   lec_top_state_type st_next;

   logic [63:0] reg_view [LEC_REGS];
   logic [5:0]  ev_in;
   logic [5:0]  slice_ld;
   logic        mr_hit;
   logic [2:0]  mr_off;
   logic        pc_hit;
   logic [2:0]  pc_off;
   logic [31:0] mr_delta;
   logic [31:0] pc_delta;

   // events in address order: two inbound, two snoop, two bus
   assign ev_in = {external_bus_event,
                   snoop_queue_event,
                   inbound_bus_queue_event};

   // address window decode; anything outside answers with an error
   assign mr_delta = mr_addr - LEC_ADDR_IBQ0;
   assign mr_hit   = (mr_addr >= LEC_ADDR_IBQ0) &&
                     (mr_addr <= LEC_ADDR_LCNT);
   assign mr_off   = mr_delta[2:0];

   // counter-read index window, mapped back onto register order
   assign pc_delta = pc_index - LEC_PMC_FIRST;
   assign pc_hit   = (pc_index >= LEC_PMC_FIRST) &&
                     (pc_index <= LEC_PMC_LAST);
   assign pc_off   = pc_delta[2:0];

   lec_slice_if sif [LEC_SLICES] ();

   // one counter slice per qualified event register
   genvar gi;
   generate
      for (gi = 0; gi < LEC_SLICES; gi++) begin : g_slice
         assign slice_ld[gi] = mr_wr && mr_hit &&
                               (mr_off == 3'(gi));
         assign sif[gi].ld      = slice_ld[gi];
         assign sif[gi].ld_data = mr_wdata;
         assign sif[gi].evt     = ev_in[gi];
         assign reg_view[gi]    = sif[gi].value;
         assign ev_armed[gi]    = sif[gi].armed;
         assign ev_qual[gi*LEC_HALF +: LEC_HALF] =
            sif[gi].value[63:32];

         lec_event_slice u_slice (
            .sys_clk (sys_clk),
            .rst_b   (rst_b),
            .sif     (sif[gi])
         );
      end
   endgenerate

   // latency pair completes the eight-register view
   assign reg_view[LEC_IDX_LCTL] = st_reg.lat_ctl;
   assign reg_view[LEC_IDX_LCNT] = st_reg.lat_cnt;

   // next-state: latency pair, register answers, counter-read answers
   always_comb begin
      st_next        = st_reg;
      st_next.mr_ack = 1'b0;
      st_next.mr_err = 1'b0;
      st_next.pc_ack = 1'b0;
      st_next.pc_err = 1'b0;

      // latency accumulation only while the enable bit is set;
      // once cleared the sum simply holds
      if (st_reg.lat_ctl[LEC_LAT_EN_BIT]) begin
         st_next.lat_cnt = st_reg.lat_cnt +
                           {48'h0000_0000_0000, lat_weight};
      end

      // full-word writes; a write to the counter beats accumulation
      if (mr_wr && mr_hit) begin
         if (mr_off == LEC_IDX_LCTL) begin
            st_next.lat_ctl = mr_wdata;
         end
         if (mr_off == LEC_IDX_LCNT) begin
            st_next.lat_cnt = mr_wdata;
         end
      end

      // every request is answered once, a cycle later; a write in
      // the same cycle as a read wins and the read data is not updated
      if (mr_rd || mr_wr) begin
         st_next.mr_ack = 1'b1;
         st_next.mr_err = !mr_hit;
         if (mr_rd && !mr_wr) begin
            if (mr_hit) begin
               st_next.mr_rdata = reg_view[mr_off];
            end else begin
               st_next.mr_rdata = LEC_RST_WORD;
            end
         end
      end

      // counter read returns only the low half; unknown index errors
      if (pc_rd) begin
         st_next.pc_ack = 1'b1;
         st_next.pc_err = !pc_hit;
         if (pc_hit) begin
            st_next.pc_lo = reg_view[pc_off][31:0];
         end else begin
            st_next.pc_lo = LEC_PC_HI;
         end
      end
   end

   // single registered state copy
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign mr_rdata    = st_reg.mr_rdata;
   assign mr_ack      = st_reg.mr_ack;
   assign mr_err      = st_reg.mr_err;
   assign pc_rdata_lo = st_reg.pc_lo;
   assign pc_rdata_hi = LEC_PC_HI;
   assign pc_ack      = st_reg.pc_ack;
   assign pc_err      = st_reg.pc_err;
   assign lat_active  = st_reg.lat_ctl[LEC_LAT_EN_BIT];
endmodule

// >>> rtl/lec_pkg.sv
// Notes on behaviour
// - low half of each of the six event registers is a 32-bit counter
// - counter-read indices 18 to 25 return the low halves of all eight registers, latency control included, in address order
// - counter-read upper result half is always zero for these counters
// - four classes: inbound queue, snoop queue, external bus, latency
// - inbound queue registers: upper half qualifies, lower half counts
// - inbound queue counter runs only once its upper half is non-zero
// - snoop queue registers count low, run once upper half is non-zero
// - snoop queue counters count their event input while any upper qualification bit is set
// - bus data-ready registers count low, qualified by upper half
// - bus data-ready counter runs once an upper qualification bit is set
// - latency counter adds weighted cycles while control bit 26 is set
// - clearing control bit 26 stops latency accumulation, value held
// - latency counter is a full 64-bit accumulator
package lec_pkg;

   localparam int unsigned LEC_REGS     = 8;
   localparam int unsigned LEC_SLICES   = 6;
   localparam int unsigned LEC_HALF     = 32;
   localparam int unsigned LEC_WIDTH    = 64;
   localparam int unsigned LEC_WEIGHT_W = 16;

   // register addresses in the model-register space
   localparam logic [31:0] LEC_ADDR_IBQ0 = 32'h0001_07cc;
   localparam logic [31:0] LEC_ADDR_IBQ1 = 32'h0001_07cd;
   localparam logic [31:0] LEC_ADDR_SNQ0 = 32'h0001_07ce;
   localparam logic [31:0] LEC_ADDR_SNQ1 = 32'h0001_07cf;
   localparam logic [31:0] LEC_ADDR_BDR0 = 32'h0001_07d0;
   localparam logic [31:0] LEC_ADDR_BDR1 = 32'h0001_07d1;
   localparam logic [31:0] LEC_ADDR_LCTL = 32'h0001_07d2;
   localparam logic [31:0] LEC_ADDR_LCNT = 32'h0001_07d3;

   // register positions relative to the first address
   localparam logic [2:0] LEC_IDX_LCTL = 3'h6;
   localparam logic [2:0] LEC_IDX_LCNT = 3'h7;

   // counter-read index window
   localparam logic [31:0] LEC_PMC_FIRST = 32'h0000_0012;
   localparam logic [31:0] LEC_PMC_LAST  = 32'h0000_0019;

   // field positions
   localparam int unsigned LEC_LAT_EN_BIT = 26;

   // reset values (none documented, cleared)
   localparam logic [63:0] LEC_RST_WORD = 64'h0000_0000_0000_0000;
   localparam logic [31:0] LEC_PC_HI    = 32'h0000_0000;
   localparam logic [31:0] LEC_ONE      = 32'h0000_0001;

   typedef struct packed {
      logic [31:0] qual;
      logic [31:0] count;
   } lec_slice_state_type;

endpackage

// >>> rtl/lec_slice_if.sv
`timescale 1ns/1ns
interface lec_slice_if;
   logic        ld;
   logic [63:0] ld_data;
   logic        evt;
   logic [63:0] value;
   logic        armed;

   modport host (
      output ld,
      output ld_data,
      output evt,
      input  value,
      input  armed
   );
   modport slice (
      input  ld,
      input  ld_data,
      input  evt,
      output value,
      output armed
   );
endinterface

// >>> rtl/lec_event_slice.sv
`timescale 1ns/1ns
module lec_event_slice
   import lec_pkg::*;
(
   input wire logic   sys_clk,
   input wire logic   rst_b,
   lec_slice_if.slice sif
);

   lec_slice_state_type s_reg;
   lec_slice_state_type s_next;

   // a counter is armed by any set bit of its qualification half
   always_comb begin
      s_next = s_reg;
      if (sif.ld) begin
         s_next = sif.ld_data;
      end else if ((|s_reg.qual) && sif.evt) begin
         s_next.count = s_reg.count + LEC_ONE;
      end
   end

   // write beats a same-cycle event: software load must land exactly
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         s_reg <= LEC_RST_WORD;
      end else begin
         s_reg <= s_next;
      end
   end

   // qualification half stays visible for the event logic outside
   assign sif.value = s_reg;
   assign sif.armed = |s_reg.qual;
endmodule

// >>> testbench/lec_event_counters_checker.sv
`timescale 1ns/1ns
module lec_event_counters_checker
   import lec_pkg::*;
(
   input wire logic         sys_clk,
   input wire logic         rst_b,
   input wire logic [31:0]  mr_addr,
   input wire logic         mr_rd,
   input wire logic         mr_wr,
   input wire logic [63:0]  mr_wdata,
   input wire logic         mr_ack,
   input wire logic         mr_err,
   input wire logic         pc_rd,
   input wire logic [31:0]  pc_index,
   input wire logic [31:0]  pc_rdata_hi,
   input wire logic         pc_ack,
   input wire logic         pc_err,
   input wire logic [191:0] ev_qual,
   input wire logic [5:0]   ev_armed,
   input wire logic         lat_active
);
   logic [5:0] nz;
   logic       hit;
   logic       ok;
   logic [2:0] wi;
   logic       lw;
   // request decodes; the index wraps, so only slots below six are judged
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         nz[i] = |ev_qual[32*i +: 32];
      end
   end
   assign hit = mr_addr >= LEC_ADDR_IBQ0 && mr_addr <= LEC_ADDR_LCNT;
   assign ok  = pc_index >= LEC_PMC_FIRST && pc_index <= LEC_PMC_LAST;
   assign wi  = 3'(mr_addr - LEC_ADDR_IBQ0);
   assign lw  = mr_wr && mr_addr == LEC_ADDR_LCTL;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   a_bus_answer: assert property (
      (mr_rd || mr_wr) |=> mr_ack && mr_err == !$past(hit))
      else $error("bus answer wrong");
   a_no_stray_ack: assert property (
      mr_ack |-> $past(mr_rd || mr_wr)) else $error("stray ack");
   a_pc_answer: assert property (
      pc_rd |=> pc_ack && pc_err == !$past(ok)) else $error("pc answer");
   a_pc_hi_zero: assert property (
      pc_rdata_hi == 32'h0000_0000) else $error("pc high not zero");
   a_armed_match: assert property (
      ev_armed == nz) else $error("armed wrong");
   a_qual_load: assert property (
      mr_wr && hit && wi < 3'h6 |=>
      32'(ev_qual >> (32 * $past(wi))) == $past(mr_wdata[63:32]))
      else $error("qual not loaded");
   a_lat_follows: assert property (
      lw |=> lat_active == $past(mr_wdata[LEC_LAT_EN_BIT]))
      else $error("latency enable wrong");
   a_lat_only_write: assert property (
      $changed(lat_active) && $past(rst_b) |-> $past(lw))
      else $error("latency enable moved");
   c_bad_index: cover property (pc_rd && !ok);
   c_unmapped: cover property (mr_rd && !hit);
   c_lat_on: cover property (lat_active);
endmodule

// >>> testbench/lec_event_counters_tb_top.sv
`timescale 1ns/1ns
module lec_event_counters_tb_top;
   import lec_pkg::*;
   logic          sys_clk, rst_b, mr_rd, mr_wr, mr_ack, mr_err;
   logic          pc_rd, pc_ack, pc_err, lat_active;
   logic [31:0]   mr_addr, pc_index, pc_rdata_lo, pc_rdata_hi;
   logic [63:0]   mr_wdata, mr_rdata, q;
   logic [5:0]    ev, ev_armed;
   logic [15:0]   lat_weight;
   logic [191:0]  ev_qual;
   logic [31:0]   shadow [8];
   int            num_errors, checked;
   lec_event_counters lec_event_counters_i (
      .sys_clk(sys_clk), .rst_b(rst_b), .mr_addr(mr_addr), .mr_rd(mr_rd),
      .mr_wr(mr_wr), .mr_wdata(mr_wdata), .mr_rdata(mr_rdata),
      .mr_ack(mr_ack), .mr_err(mr_err), .pc_rd(pc_rd),
      .pc_index(pc_index), .pc_rdata_lo(pc_rdata_lo),
      .pc_rdata_hi(pc_rdata_hi), .pc_ack(pc_ack), .pc_err(pc_err),
      .inbound_bus_queue_event(ev[1:0]), .snoop_queue_event(ev[3:2]),
      .external_bus_event(ev[5:4]), .lat_weight(lat_weight),
      .ev_qual(ev_qual), .ev_armed(ev_armed), .lat_active(lat_active));
   // 25 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic check(string w, logic [63:0] s, logic [63:0] e);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", w, e, s);
      end
   endtask
   // one request, released after the edge that takes it; answer is fixed
   task automatic op(logic wr, logic [31:0] a, logic [63:0] d, logic e);
      @(negedge sys_clk);
      mr_rd = !wr;
      mr_wr = wr;
      mr_addr = a;
      mr_wdata = d;
      @(negedge sys_clk);
      mr_rd = 1'b0;
      mr_wr = 1'b0;
      check("mr_ack", 64'(mr_ack), 64'h1);
      check("mr_err", 64'(mr_err), 64'(e));
   endtask
   // read back; the low half is kept for the counter-read sweep
   task automatic rd(logic [31:0] a, logic [63:0] e);
      op(1'b0, a, 64'h0, 1'b0);
      check("mr_rdata", mr_rdata, e);
      shadow[3'(a - LEC_ADDR_IBQ0)] = e[31:0];
   endtask
   task automatic pc(logic [31:0] i, logic [31:0] lo, logic e);
      @(negedge sys_clk);
      pc_rd = 1'b1;
      pc_index = i;
      @(negedge sys_clk);
      pc_rd = 1'b0;
      check("pc_data", {pc_rdata_hi, pc_rdata_lo}, 64'(lo));
      check("pc_ack", 64'(pc_ack), 64'h1);
      check("pc_err", 64'(pc_err), 64'(e));
   endtask
   // events and weight stand for exactly k sampling edges
   task automatic pulse(logic [5:0] m, int k, logic [15:0] w);
      @(negedge sys_clk);
      ev = m;
      lat_weight = w;
      repeat (k) @(negedge sys_clk);
      ev = 6'h00;
      lat_weight = 16'h0000;
   endtask
   task automatic end_of_test();
      $display("checked %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // watchdog far beyond the roughly 110 cycles the tests need
   initial begin
      repeat (3000) @(posedge sys_clk);
      num_errors++;
      end_of_test();
   end
   initial begin
      {mr_rd, mr_wr, pc_rd, rst_b} = 4'h0;
      {mr_addr, pc_index, mr_wdata, ev, lat_weight} = '0;
      repeat (12) @(negedge sys_clk);
      rst_b = 1'b1;
      for (int i = 0; i < 8; i++) rd(LEC_ADDR_IBQ0 + 32'(i), 64'h0);
      op(1'b0, LEC_ADDR_IBQ0 - 32'h1, 64'h0, 1'b1);
      check("unmapped", mr_rdata, 64'h0);
      op(1'b0, LEC_ADDR_LCNT + 32'h1, 64'h0, 1'b1);
      $display("test reset done");
      // only even slots armed, so odd ones must ignore their events
      for (int i = 0; i < 6; i += 2) begin
         op(1'b1, LEC_ADDR_IBQ0 + 32'(i), 64'h1 << (32 + 5 * i), 1'b0);
      end
      pulse(6'h3f, 5, 16'h0000);
      check("ev_armed", 64'(ev_armed), 64'h15);
      for (int i = 0; i < 6; i++) begin
         q = i[0] ? 64'h0 : (64'h1 << (32 + 5 * i)) | 64'h5;
         rd(LEC_ADDR_IBQ0 + 32'(i), q);
      end
      check("ev_qual", 64'(ev_qual[95:64]), 64'h0000_0400);
      op(1'b1, LEC_ADDR_SNQ1, 64'h0000_0100_ffff_fffe, 1'b0);
      pulse(6'h08, 3, 16'h0000);
      rd(LEC_ADDR_SNQ1, 64'h0000_0100_0000_0001);
      $display("test events done");
      op(1'b1, LEC_ADDR_LCNT, 64'h0000_0000_ffff_ffff, 1'b0);
      op(1'b1, LEC_ADDR_LCTL, 64'h0000_0000_0400_0000, 1'b0);
      check("lat_active", 64'(lat_active), 64'h1);
      pulse(6'h00, 4, 16'h0103);
      q = 64'h0000_0000_ffff_ffff + 64'h0000_0000_0000_0103 * 4;
      rd(LEC_ADDR_LCNT, q);
      op(1'b1, LEC_ADDR_LCTL, 64'h0000_0000_03ff_ffff, 1'b0);
      check("lat_active", 64'(lat_active), 64'h0);
      rd(LEC_ADDR_LCTL, 64'h0000_0000_03ff_ffff);
      pulse(6'h00, 4, 16'h0103);
      rd(LEC_ADDR_LCNT, q);
      // a write just past the window must not alias onto slot 0
      op(1'b1, LEC_ADDR_LCNT + 32'h1, 64'hffff_ffff_ffff_ffff, 1'b1);
      $display("test latency done");
      for (int i = 17; i < 27; i++) begin
         if (i < 18 || i > 25) pc(32'(i), 32'h0, 1'b1);
         else pc(32'(i), shadow[i-18], 1'b0);
      end
      $display("test counter read done");
      end_of_test();
   end
endmodule
bind lec_event_counters lec_event_counters_checker
   lec_event_counters_checker_i (
   .sys_clk(sys_clk), .rst_b(rst_b), .mr_addr(mr_addr), .mr_rd(mr_rd),
   .mr_wr(mr_wr), .mr_wdata(mr_wdata), .mr_ack(mr_ack), .mr_err(mr_err),
   .pc_rd(pc_rd), .pc_index(pc_index), .pc_rdata_hi(pc_rdata_hi),
   .pc_ack(pc_ack), .pc_err(pc_err), .ev_qual(ev_qual),
   .ev_armed(ev_armed), .lat_active(lat_active));
